// ==== rtl/rpgs_sequencer.sv ====
// reset pin group sequencer: reset filter, boot capture, pin group gating
// ---------------------------------------------------------------
// Notes on behaviour
// ---------------------------------------------------------------
// Notes on behaviour
// RULE1: with the multiplier stable the board holds reset low for at least ten cpu periods.
// RULE2: when the multiplier must still lock the board holds reset low for at least 250 us, never needed in x1.
// RULE3: reset does not reset the multiplier, so the board covers the lock time after power-up or config change.
// RULE4: the 32 expansion data pins are captured at reset release and held valid five periods either side.
// RULE5: the half-rate clock goes invalid no sooner than a period after reset low and runs within four after high.
// RULE6: fifo clock and bus hold ack go invalid a period after reset low and are valid within four after high.
// RULE7: interrupt ack, number, dma events, power-down and timer outputs follow the same low-group timing.
// RULE8: the z group floats a period after reset low and is driven again within four periods after release.
// RULE9: ten periods suffice in x1 once the input clock is stable, in multiplied modes only with multiplier lock.
// RULE10: reset release is synchronised to the cpu clock before internal state and boot capture are released.
`timescale 1ns/1ps
module rpgs_sequencer
    import rpgs_pkg::*;
#(
    parameter int LOCK_CYC = RST_MIN_LOCK_CYC
) (
    // clock and internal reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pins and status
    input wire logic reset_pin_n,
    input wire logic mult_locked,
    input wire logic clk_mult_x1,
    input wire logic [CFG_W-1:0] expansion_data_pins,
    // core side
    output logic core_reset_n,
    output logic [CFG_W-1:0] boot_config,
    output logic short_reset_err,
    output rpgs_groups_s groups
);
    // ---------------------------------------------------------------
    // reset pin synchroniser, three stages
    // ---------------------------------------------------------------
    // starts at the idle pin level so leaving block reset is never a release
    logic [2:0] rst_sync_ff;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rst_sync_ff <= RST_SYNC_IDLE;
        end else begin
            rst_sync_ff <= {rst_sync_ff[1:0], reset_pin_n};
        end
    end

    // filtered level moves only once stages two and three agree
    logic rst_lvl_ff;
    logic rst_lvl;
    always_comb begin
        if (rst_sync_ff[1] == rst_sync_ff[2]) begin
            rst_lvl = rst_sync_ff[2]; // [RULE10]
        end else begin
            rst_lvl = rst_lvl_ff;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rst_lvl_ff <= RST_SYNC_IDLE[2];
        end else begin
            rst_lvl_ff <= rst_lvl;
        end
    end

    // rise reached stage two, not yet confirmed by stage three
    logic rst_rise_seen;
    assign rst_rise_seen = rst_sync_ff[1] && !rst_sync_ff[2];

    // ---------------------------------------------------------------
    // strap synchroniser, three stages per expansion data pin
    // ---------------------------------------------------------------
    logic [CFG_W-1:0] strap_s1_ff;
    logic [CFG_W-1:0] strap_s2_ff;
    logic [CFG_W-1:0] strap_s3_ff;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            strap_s1_ff <= CFG_RESET;
            strap_s2_ff <= CFG_RESET;
            strap_s3_ff <= CFG_RESET;
        end else begin
            strap_s1_ff <= expansion_data_pins;
            strap_s2_ff <= strap_s1_ff;
            strap_s3_ff <= strap_s2_ff;
        end
    end

    // per pin filter: a bit takes stage three only where stage two agrees
    logic [CFG_W-1:0] strap_lvl_ff;
    logic [CFG_W-1:0] strap_lvl;
    logic [CFG_W-1:0] strap_agree;
    assign strap_agree = ~(strap_s2_ff ^ strap_s3_ff);
    assign strap_lvl = (strap_s3_ff & strap_agree) | (strap_lvl_ff & ~strap_agree);
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            strap_lvl_ff <= CFG_RESET;
        end else begin
            strap_lvl_ff <= strap_lvl;
        end
    end

    // ---------------------------------------------------------------
    // low width counter on the filtered level
    // ---------------------------------------------------------------
    // saturates so a very long reset cannot wrap back below the limit
    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        if (v == CNT_MAX) begin
            return v;
        end
        return v + CNT_ONE;
    endfunction

    logic [CNT_W-1:0] low_cnt_ff;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            low_cnt_ff <= CNT_ZERO;
        end else if (rst_lvl) begin
            low_cnt_ff <= CNT_ZERO;
        end else begin
            low_cnt_ff <= sat_inc(low_cnt_ff);
        end
    end

    // lock wait only matters in multiplied modes without lock
    logic [CNT_W-1:0] need_cnt;
    always_comb begin
        if (clk_mult_x1 || mult_locked) begin
            need_cnt = CNT_W'(RST_MIN_STABLE_P); // [RULE1] [RULE9]
        end else begin
            need_cnt = CNT_W'(LOCK_CYC); // [RULE2] [RULE3]
        end
    end

    // ---------------------------------------------------------------
    // state machine
    // ---------------------------------------------------------------
    rpgs_state_e state_ff;
    rpgs_state_e nxt_state;
    logic width_ok;
    assign width_ok = (low_cnt_ff >= need_cnt);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            RPGS_IN_RESET: begin
                if (rst_rise_seen) begin
                    nxt_state = RPGS_RELEASING;
                end
            end
            RPGS_RELEASING: begin
                // release lands one edge after the filter confirms, four periods after the pin
                if (rst_lvl && width_ok) begin
                    nxt_state = RPGS_RUN;
                end else begin
                    nxt_state = RPGS_IN_RESET;
                end
            end
            RPGS_RUN: begin
                if (!rst_lvl) begin
                    nxt_state = RPGS_IN_RESET;
                end
            end
            default: begin
                nxt_state = RPGS_IN_RESET;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_ff <= RPGS_IN_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // too short pulse is flagged; the block stays held until a full pulse
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            short_reset_err <= 1'b0;
        end else if (rst_lvl && !width_ok && low_cnt_ff != CNT_ZERO) begin
            short_reset_err <= 1'b1;
        end else if (nxt_state == RPGS_RUN) begin
            short_reset_err <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // boot capture at release
    // ---------------------------------------------------------------
    // filtered straps were taken a period after release, well inside the hold time
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            boot_config <= CFG_RESET;
        end else if (state_ff != RPGS_RUN && nxt_state == RPGS_RUN) begin
            boot_config <= strap_lvl; // [RULE4]
        end
    end

    // ---------------------------------------------------------------
    // pin group gating
    // ---------------------------------------------------------------
    // taken from the next state: the filter delays invalidation, release still fits four periods
    logic run_ff;
    rpgs_groups_s groups_ff;
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            run_ff <= 1'b0;
        end else begin
            run_ff <= (nxt_state == RPGS_RUN); // [RULE10]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            groups_ff.clk2_valid <= 1'b0;
            groups_ff.high_valid <= 1'b0;
            groups_ff.low_valid <= 1'b0;
            groups_ff.z_drive <= 1'b0;
        end else begin
            groups_ff.clk2_valid <= (nxt_state == RPGS_RUN); // [RULE5]
            groups_ff.high_valid <= (nxt_state == RPGS_RUN); // [RULE6]
            groups_ff.low_valid <= (nxt_state == RPGS_RUN); // [RULE7]
            groups_ff.z_drive <= (nxt_state == RPGS_RUN); // [RULE8]
        end
    end

    assign core_reset_n = run_ff; // [RULE10]
    assign groups = groups_ff;
endmodule

// ==== rtl/rpgs_pkg.sv ====
// package for the reset pin group sequencer
package rpgs_pkg;
    // cpu clock period in ns
    localparam int CLK_PERIOD_NS = 10;
    // reset pulse widths
    localparam int RST_MIN_STABLE_P = 10;
    localparam int RST_MIN_LOCK_US = 250;
    localparam int RST_MIN_LOCK_CYC = (RST_MIN_LOCK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // boot configuration setup and hold, in cpu periods
    localparam int CFG_SETUP_P = 5;
    localparam int CFG_HOLD_P = 5;
    // release of pin groups, in cpu periods after reset high
    localparam int RELEASE_MAX_P = 4;
    // reset pin synchroniser starts at the idle (released) pin level
    localparam logic [2:0] RST_SYNC_IDLE = 3'h7;
    localparam int CNT_W = 16;
    localparam int CFG_W = 32;
    localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [CFG_W-1:0] CFG_RESET = 32'h0000_0000;

    typedef enum logic [1:0] {
        RPGS_IN_RESET = 2'b00,
        RPGS_RELEASING = 2'b01,
        RPGS_RUN = 2'b11
    } rpgs_state_e;

    // pin group enables handed to the pad ring
    typedef struct packed {
        logic clk2_valid;
        logic high_valid;
        logic low_valid;
        logic z_drive;
    } rpgs_groups_s;
endpackage

// ==== dv/rpgs_seq_props.sv ====
// port assertions for the reset pin group sequencer
`timescale 1ns/1ps
module rpgs_seq_props
    import rpgs_pkg::*;
#(
    parameter int LOCK_CYC = RST_MIN_LOCK_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // watched ports
    input wire logic reset_pin_n,
    input wire logic mult_locked,
    input wire logic clk_mult_x1,
    input wire logic [CFG_W-1:0] expansion_data_pins,
    input wire logic core_reset_n,
    input wire logic [CFG_W-1:0] boot_config,
    input wire logic short_reset_err,
    input wire rpgs_groups_s groups
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    AST_GRP_EQ:
        assert property (groups == {4{core_reset_n}}) else $error("pin groups differ from core reset");
    AST_NO_EARLY_DROP:
        assert property (core_reset_n && $fell(reset_pin_n) |=> core_reset_n) else $error("groups dropped early");
    AST_DROP:
        assert property (!reset_pin_n [*4] |-> ##[0:3] !core_reset_n) else $error("reset not taken");
    AST_REL_PIN:
        assert property ($rose(core_reset_n) |-> reset_pin_n) else $error("release with pin low");
    AST_REL_WIDTH:
        assert property ($rose(core_reset_n) |-> !$past(reset_pin_n, 14)) else $error("release after short pulse");
    AST_REL_4P:
        assert property ($rose(core_reset_n) |-> $past(reset_pin_n, 4) && !$past(reset_pin_n, 5))
            else $error("release not four periods after pin rise");
    AST_CFG_STABLE:
        assert property (core_reset_n && $past(core_reset_n) |-> $stable(boot_config)) else $error("config moved");
    AST_CFG_VAL:
        assert property ($rose(core_reset_n) |-> boot_config == $past(expansion_data_pins, 6))
            else $error("config not the straps");
    AST_ERR_CLR:
        assert property (core_reset_n |-> !short_reset_err) else $error("error flag set in run");
endmodule
bind rpgs_sequencer rpgs_seq_props #(.LOCK_CYC(LOCK_CYC)) i_props (.sys_clk(sys_clk), .reset_n(reset_n),
    .reset_pin_n(reset_pin_n), .mult_locked(mult_locked), .clk_mult_x1(clk_mult_x1),
    .expansion_data_pins(expansion_data_pins), .core_reset_n(core_reset_n), .boot_config(boot_config),
    .short_reset_err(short_reset_err), .groups(groups));

// ==== dv/rpgs_board_model.sv ====
// board reset supervisor with boot strap resistors
`timescale 1ns/1ps
module rpgs_board_model (
    // clock seen by the board
    input wire logic sys_clk,
    // driven pins
    output logic reset_pin_n,
    output logic [31:0] expansion_data_pins
);
    initial begin
        reset_pin_n = 1'b1;
        expansion_data_pins = 32'hFFFF_FFFF;
    end
    // straps are set with the pin fall, so setup covers the whole low time
    task automatic press(input int w, input logic [31:0] cfg);
        @(posedge sys_clk);
        expansion_data_pins <= cfg;
        reset_pin_n <= 1'b0;
        repeat (w) @(posedge sys_clk);
        reset_pin_n <= 1'b1;
        repeat (5) @(posedge sys_clk);
        expansion_data_pins <= ~cfg;
    endtask
endmodule

// ==== dv/reset_pin_group_sequencer_tb.sv ====
// testbench for the reset pin group sequencer
`timescale 1ns/1ps
module reset_pin_group_sequencer_tb;
    import rpgs_pkg::*;
    localparam int LOCK = 20;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic mult_locked = 1'b0;
    logic clk_mult_x1 = 1'b1;
    logic reset_pin_n, core_reset_n, short_reset_err;
    logic [CFG_W-1:0] expansion_data_pins, boot_config, cfg;
    rpgs_groups_s groups;
    int n_errors = 0;
    int comparisons = 0;
    int w, x1, lk;
    logic ok;
    // corner cases: width boundaries in each clock mode
    int cw[6] = '{10, 9, 19, 20, 10, 9};
    int cx[6] = '{1, 1, 0, 0, 0, 0};
    int cl[6] = '{0, 0, 0, 0, 1, 1};
    always #5 sys_clk = ~sys_clk;
    rpgs_board_model i_board (.sys_clk(sys_clk), .reset_pin_n(reset_pin_n),
        .expansion_data_pins(expansion_data_pins));
    rpgs_sequencer #(.LOCK_CYC(LOCK)) i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reset_pin_n(reset_pin_n),
        .mult_locked(mult_locked), .clk_mult_x1(clk_mult_x1), .expansion_data_pins(expansion_data_pins),
        .core_reset_n(core_reset_n), .boot_config(boot_config), .short_reset_err(short_reset_err),
        .groups(groups));
    function automatic int need(input int x1m, input int lkm);
        return (x1m != 0 || lkm != 0) ? RST_MIN_STABLE_P : LOCK;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        void'($urandom(58));
        repeat (16) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            w = i < 6 ? cw[i] : 8 + $urandom % 16;
            x1 = i < 6 ? cx[i] : $urandom % 2;
            lk = i < 6 ? cl[i] : $urandom % 2;
            cfg = $urandom;
            @(posedge sys_clk);
            clk_mult_x1 <= x1[0];
            mult_locked <= lk[0];
            ok = w >= need(x1, lk);
            i_board.press(w, cfg);
            // five periods after pin rise the groups must already be valid after a full pulse, still invalid after a short one
            #1;
            check(32'(groups), 32'({4{ok}}));
            repeat (8) @(posedge sys_clk);
            #1;
            check(32'(core_reset_n), 32'(ok));
            check(32'(groups), 32'({4{ok}}));
            check(32'(short_reset_err), 32'(!ok));
            if (ok) check(boot_config, cfg);
        end
        wrap_up;
    end
    initial begin
        repeat (3000) @(posedge sys_clk);
        n_errors++;
        wrap_up;
    end
endmodule
